/* File: wk_regs.svh */
// Register offsets, field positions, reset values and frame counts of the wake trim bank
`ifndef WK_REGS_SVH
`define WK_REGS_SVH

// ----------------------------------------
// Register offsets (7-bit serial address)
// ----------------------------------------
`define WK_ADDR_TRIM_LOW   7'h38
`define WK_ADDR_OPTIONS    7'h39
`define WK_ADDR_CAL_HIGH   7'h3a
`define WK_ADDR_CAL_LOW    7'h3b
`define WK_ADDR_CTRL_ONE   7'h3c
`define WK_ADDR_CTRL_TWO   7'h3d

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WK_OPT_RX_BIT      7
`define WK_CTRL1_EN_BIT    0
`define WK_CTRL1_FILT_LSB  2
`define WK_CTRL2_CLK_LSB   0

// ----------------------------------------
// Reset values and unlock code
// ----------------------------------------
`define WK_CAL_RESET       8'h00
`define WK_CTRL1_RESET     8'h04
`define WK_CTRL2_RESET     8'h00
`define WK_TRIM_UNLOCK     2'h3

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define WK_FRAME_BITS      5'h10
`define WK_ADDR_BITS       5'h08

`endif

/* File: wk_pkg.sv */
// Types shared by the wake trim register bank
package wk_pkg;
  typedef logic [6:0] wk_addr_t;
  typedef logic [7:0] wk_byte_t;
  // Recovery clock selections
  typedef enum logic [1:0] {
    WK_CLK_80M = 2'b00,
    WK_CLK_40M = 2'b01,
    WK_CLK_20M = 2'b10,
    WK_CLK_10M = 2'b11
  } wk_clk_sel_e;
endpackage

/* File: wk_trim_cdr.sv */
// Wake receive path trim, calibration and recovery control registers behind a 16-bit serial port
`timescale 1ns/1ns
`include "wk_regs.svh"
// What this block does
// - Trim bits 7:0 writable only when unlocked
// - Coarse trim at options 4:0, unlocked only
// - Trim bits 4:0 are monotonic fine steps
// - Options bit 7 picks wake receiver
// - Two read-only calibration bytes reset zero
// - Control one bit 0 enables recovery
// - Control two bits 1:0 pick clock
// - Reserved bits read zero, ignore writes
// - Reset clears options 7:5, keeps preset
module wk_trim_cdr
  import wk_pkg::*;
#(
  parameter logic [12:0] TRIM_PRESET = 13'h0000
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        soft_rst,
  // Serial register port
  input  wire logic        spi_sclk,
  input  wire logic        spi_csn,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe_n,
  // Trim unlock field and calibration source
  input  wire logic [1:0]  trim_enable,
  input  wire logic [15:0] cal_result_in,
  // Controls toward oscillator and recovery
  output logic [12:0]      oscillator_tune_code,
  output logic             wake_receiver_choice,
  output logic             recovery_enable,
  output logic [1:0]       recovery_filter_choice,
  output wk_clk_sel_e      recovery_clock_choice,
  output logic [7:0]       calibration_result_high,
  output logic [7:0]       calibration_result_low
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0]  sclk_q;
  logic [2:0]  csn_q;
  logic [1:0]  sdi_q;
  logic [15:0] shift_in;
  logic [4:0]  bit_cnt;
  logic [7:0]  out_shift;

  // Reset images of the recovery control registers, so single fields can be picked
  localparam logic [7:0] CTRL1_RST = `WK_CTRL1_RESET;
  localparam logic [7:0] CTRL2_RST = `WK_CTRL2_RESET;

  // Two flops per pin, a third only for edge detection
  always_ff @(posedge mclk) begin
    sclk_q <= {sclk_q[1:0], spi_sclk};
    csn_q  <= {csn_q[1:0], spi_csn};
    sdi_q  <= {sdi_q[0], spi_sdi};
  end

  // Edge and frame decode
  wire       rst_any    = srst | soft_rst;
  wire       sel        = ~csn_q[1];
  wire       sclk_rise  = sel & sclk_q[1] & ~sclk_q[2];
  wire       sclk_fall  = sel & ~sclk_q[1] & sclk_q[2];
  wire       frame_end  = csn_q[1] & ~csn_q[2];
  wire [6:0] rd_addr    = shift_in[14:8];
  wire [6:0] wr_addr    = shift_in[6:0];
  wire [7:0] wr_data    = shift_in[15:8];
  wire       wr_commit  = frame_end & (bit_cnt == `WK_FRAME_BITS) & shift_in[7];
  wire       unlocked   = (trim_enable == `WK_TRIM_UNLOCK);
  wire       wr_trim    = wr_commit & (wr_addr == `WK_ADDR_TRIM_LOW) & unlocked;
  wire       wr_opt     = wr_commit & (wr_addr == `WK_ADDR_OPTIONS) & unlocked;
  wire       wr_ctrl1   = wr_commit & (wr_addr == `WK_ADDR_CTRL_ONE);
  wire       wr_ctrl2   = wr_commit & (wr_addr == `WK_ADDR_CTRL_TWO);
  wire       load_rd    = sclk_fall & (bit_cnt == `WK_ADDR_BITS);

  // ----------------------------------------
  // Read mux, reserved bits as zero
  // ----------------------------------------
  wire [7:0] rd_trim  = oscillator_tune_code[7:0];
  wire [7:0] rd_opt   = {wake_receiver_choice, 2'b00, oscillator_tune_code[12:8]};
  wire [7:0] rd_ctrl1 = {4'h0, recovery_filter_choice, 1'b0, recovery_enable};
  wire [7:0] rd_ctrl2 = {6'h00, recovery_clock_choice};
  wire [7:0] rd_data  =
    (rd_addr == `WK_ADDR_TRIM_LOW) ? rd_trim :
    (rd_addr == `WK_ADDR_OPTIONS)  ? rd_opt :
    (rd_addr == `WK_ADDR_CAL_HIGH) ? calibration_result_high :
    (rd_addr == `WK_ADDR_CAL_LOW)  ? calibration_result_low :
    (rd_addr == `WK_ADDR_CTRL_ONE) ? rd_ctrl1 :
    (rd_addr == `WK_ADDR_CTRL_TWO) ? rd_ctrl2 : 8'h00;

  // ----------------------------------------
  // Serial frame engine, LSB first
  // ----------------------------------------
  // Shift in on sampled rising edges, count bits per frame
  always_ff @(posedge mclk) begin
    if (srst || !sel) begin
      bit_cnt <= (srst || frame_end) ? 5'h00 : bit_cnt;
    end else if (sclk_rise) begin
      bit_cnt <= (bit_cnt == 5'h1f) ? bit_cnt : bit_cnt + 5'h01;
    end
    if (srst) begin
      shift_in <= 16'h0000;
    end else if (sclk_rise) begin
      shift_in <= {sdi_q[1], shift_in[15:1]};
    end
  end

  // Reply: zeros during address byte, then addressed register
  always_ff @(posedge mclk) begin
    if (srst || !sel) begin
      spi_sdo   <= 1'b0;
      out_shift <= 8'h00;
    end else if (load_rd) begin
      spi_sdo   <= rd_data[0];
      out_shift <= {1'b0, rd_data[7:1]};
    end else if (sclk_fall) begin
      spi_sdo   <= out_shift[0];
      out_shift <= {1'b0, out_shift[7:1]};
    end
  end

  // Output enable low while selected
  always_ff @(posedge mclk) begin
    if (srst) begin
      spi_sdo_oe_n <= 1'b1;
    end else begin
      spi_sdo_oe_n <= ~sel;
    end
  end

  // ----------------------------------------
  // Trim and receiver selection
  // ----------------------------------------
  // Fine steps sit in bits 4:0; the whole code drives the oscillator
  always_ff @(posedge mclk) begin
    if (rst_any) begin
      oscillator_tune_code <= TRIM_PRESET;
      wake_receiver_choice <= 1'b0;
    end else begin
      if (wr_trim) begin
        oscillator_tune_code[7:0] <= wr_data;
      end
      if (wr_opt) begin
        oscillator_tune_code[12:8] <= wr_data[4:0];
        wake_receiver_choice       <= wr_data[`WK_OPT_RX_BIT];
      end
    end
  end

  // ----------------------------------------
  // Calibration result capture
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst_any) begin
      calibration_result_high <= `WK_CAL_RESET;
      calibration_result_low  <= `WK_CAL_RESET;
    end else begin
      calibration_result_high <= cal_result_in[15:8];
      calibration_result_low  <= cal_result_in[7:0];
    end
  end

  // ----------------------------------------
  // Recovery controls
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst_any) begin
      recovery_enable        <= CTRL1_RST[`WK_CTRL1_EN_BIT];
      recovery_filter_choice <= CTRL1_RST[`WK_CTRL1_FILT_LSB +: 2];
      recovery_clock_choice  <= wk_clk_sel_e'(CTRL2_RST[`WK_CTRL2_CLK_LSB +: 2]);
    end else begin
      if (wr_ctrl1) begin
        recovery_enable        <= wr_data[`WK_CTRL1_EN_BIT];
        recovery_filter_choice <= wr_data[`WK_CTRL1_FILT_LSB +: 2];
      end
      if (wr_ctrl2) begin
        recovery_clock_choice <= wk_clk_sel_e'(wr_data[`WK_CTRL2_CLK_LSB +: 2]);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_addr_done;
    load_rd ##1 1'b1;
  endsequence

  a_trim_locked: assert property (
    (wr_commit && wr_addr == `WK_ADDR_TRIM_LOW && !unlocked && !rst_any)
      |=> $stable(oscillator_tune_code))
    else $error("trim changed while locked");

  a_trim_write: assert property (
    (wr_trim && !rst_any) |=> oscillator_tune_code[7:0] == $past(wr_data))
    else $error("trim low write lost");

  a_coarse_write: assert property (
    (wr_opt && !rst_any) |=> oscillator_tune_code[12:8] == $past(wr_data[4:0]))
    else $error("coarse trim write lost");

  a_rx_select: assert property (
    (wr_commit && wr_addr == `WK_ADDR_OPTIONS && !rst_any)
      |=> wake_receiver_choice == ($past(unlocked) ? $past(wr_data[7]) : $past(wake_receiver_choice)))
    else $error("receiver choice wrong");

  a_cal_reset: assert property (
    soft_rst |=> calibration_result_high == 8'h00 && calibration_result_low == 8'h00)
    else $error("calibration not cleared");

  a_ctrl_reset: assert property (
    soft_rst |=> recovery_enable == 1'b0 && recovery_filter_choice == 2'b01
      && recovery_clock_choice == WK_CLK_80M)
    else $error("recovery controls reset wrong");

  a_clk_write: assert property (
    (wr_ctrl2 && !rst_any) |=> recovery_clock_choice == $past(wr_data[1:0]))
    else $error("clock choice write lost");

  a_reserved_zero: assert property (
    s_addr_done |-> $past(rd_addr) != `WK_ADDR_CTRL_TWO || out_shift[6:1] == 6'h00)
    else $error("reserved bits not zero");

  a_opt_reset: assert property (
    soft_rst |=> !wake_receiver_choice && oscillator_tune_code == TRIM_PRESET)
    else $error("options reset wrong");

  a_filter_write: assert property (
    (wr_ctrl1 && !rst_any) |=> recovery_filter_choice == $past(wr_data[3:2]))
    else $error("filter choice write lost");

endmodule

/* File: wake_osc_trim_cdr_regs_bench.sv */
// Self-checking bench for the wake trim and recovery control register bank
`timescale 1ns/1ns
module wake_osc_trim_cdr_regs_bench;
  import wk_pkg::*;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  localparam logic [12:0] P = 13'h0a5b;
  logic        mclk, srst, soft_rst, spi_sclk, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe_n;
  logic [1:0]  trim_enable, recovery_filter_choice;
  logic [15:0] cal_result_in;
  logic [12:0] oscillator_tune_code;
  logic        wake_receiver_choice, recovery_enable;
  wk_clk_sel_e recovery_clock_choice;
  logic [7:0]  calibration_result_high, calibration_result_low, rdat, d;
  logic [7:0]  exp_q[$];
  integer      n_errors, n_checks, seed, cyc;
  event        got_ev;

  wk_trim_cdr #(.TRIM_PRESET(P)) dut (.mclk(mclk), .srst(srst), .soft_rst(soft_rst),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .trim_enable(trim_enable), .cal_result_in(cal_result_in),
    .oscillator_tune_code(oscillator_tune_code), .wake_receiver_choice(wake_receiver_choice),
    .recovery_enable(recovery_enable), .recovery_filter_choice(recovery_filter_choice),
    .recovery_clock_choice(recovery_clock_choice),
    .calibration_result_high(calibration_result_high),
    .calibration_result_low(calibration_result_low));

  // ----------------------------------------
  // Clock, timeout and read watcher
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // Oldest expected read value is compared whenever a read frame completes
  initial begin
    forever begin
      @(got_ev);
      chk({5'h0, exp_q.pop_front()}, {5'h0, rdat});
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One 16-bit frame, LSB first, six mclk per sclk half period
  task automatic frame(input logic [6:0] a, input logic wr, input logic [7:0] dat);
    logic [15:0] w;
    w = {dat, wr, a};
    @(posedge mclk) spi_csn <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_sdi <= w[i];
      repeat (6) @(posedge mclk);
      if (i == 8) chk(13'h0, {12'h0, spi_sdo_oe_n});
      if (i > 7) rdat[i-8] = spi_sdo;
      spi_sclk <= 1'b1;
      repeat (6) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (6) @(posedge mclk);
    spi_csn <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(13'h1, {12'h0, spi_sdo_oe_n});
    if (!wr) -> got_ev;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    frame(a, 1'b0, 8'h00);
  endtask

  // Every register and output back at its reset value
  task automatic chk_reset();
    rd(7'h38, P[7:0]);
    rd(7'h39, {3'b000, P[12:8]});
    rd(7'h3a, 8'h00);
    rd(7'h3b, 8'h00);
    rd(7'h3c, 8'h04);
    rd(7'h3d, 8'h00);
    chk(P, oscillator_tune_code);
    chk(13'h004, {9'h0, recovery_filter_choice, 1'b0, recovery_enable});
    chk(13'h000, {10'h0, wake_receiver_choice, recovery_clock_choice});
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, spi_csn} = 2'b11;
    {soft_rst, spi_sclk, spi_sdi} = 3'b000;
    trim_enable = 2'b00;
    cal_result_in = 16'h0000;
    {n_errors, n_checks, cyc} = '0;
    seed = 32'h13b91a7b;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_reset();
    // Locked trim: writes must leave preset and receiver choice alone
    trim_enable <= 2'b01;
    d = 8'($random(seed));
    frame(7'h38, 1'b1, d);
    frame(7'h39, 1'b1, d | 8'h80);
    chk_reset();
    // Unlocked trim writes: fine steps move, temperature part kept
    trim_enable <= 2'b11;
    d = {P[7:5], ~P[4:0] ^ {4'($random(seed)), 1'b0}};
    frame(7'h38, 1'b1, d);
    rd(7'h38, d);
    // Low-power receiver chosen, coarse trim rewritten unchanged, reserved bits random
    d = {1'b1, 2'($random(seed)), P[12:8]};
    frame(7'h39, 1'b1, d);
    rd(7'h39, d & 8'h9f);
    chk({d[4:0], 8'h00}, {oscillator_tune_code[12:8], 8'h00});
    chk({12'h0, d[7]}, {12'h0, wake_receiver_choice});
    // Recovery control one with all reserved bits set, fields random
    d = 8'($random(seed)) | 8'hf2;
    frame(7'h3c, 1'b1, d);
    rd(7'h3c, d & 8'h0d);
    chk({9'h0, d[3:2], 1'b0, d[0]}, {9'h0, recovery_filter_choice, 1'b0, recovery_enable});
    // Every recovery clock code
    for (int c = 0; c < 4; c++) begin
      d = {6'h3f, 2'(c)};
      frame(7'h3d, 1'b1, d);
      rd(7'h3d, {6'h00, 2'(c)});
      chk({11'h0, 2'(c)}, {11'h0, recovery_clock_choice});
    end
    // Calibration bytes are read-only and follow the source
    cal_result_in <= 16'($random(seed));
    frame(7'h3a, 1'b1, 8'hff);
    frame(7'h3b, 1'b1, 8'hff);
    rd(7'h3a, cal_result_in[15:8]);
    rd(7'h3b, cal_result_in[7:0]);
    // Unmapped place reads zero
    frame(7'h10, 1'b1, 8'hff);
    rd(7'h10, 8'h00);
    // Soft reset restores all documented values
    cal_result_in <= 16'h0000;
    @(posedge mclk) soft_rst <= 1'b1;
    @(posedge mclk) soft_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_reset();
    // Let the watcher take the last read before the verdict
    repeat (2) @(posedge mclk);
    chk(13'h0, 13'(exp_q.size()));
    end_of_test();
  end
endmodule
